// file: rtl/rws_map.svh
// Address map, field positions, reset values and timing counts of the reset and wake status block
`ifndef RWS_MAP_SVH
`define RWS_MAP_SVH

// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define RWS_STATUS_ADDR 32'h80001020
`define RWS_IRQ_STAT_ADDR 32'h80001040
`define RWS_IRQ_CLR_ADDR 32'h80001044
`define RWS_IRQ_EN_ADDR 32'h80001048

// ----------------------------------------
// Field positions in the status register
// ----------------------------------------
`define RWS_POR_BIT 0
`define RWS_PLL_LO_BIT 1
`define RWS_WAKE_BIT 4
`define RWS_RING_BIT 5
`define RWS_RTC_BIT 6
`define RWS_PFAIL_BIT 7
`define RWS_WARM_BIT 8
`define RWS_WDT_BIT 9
`define RWS_SYNC_BIT 10
`define RWS_EN_LO_BIT 11
`define RWS_EN_HI_BIT 15
`define RWS_WARM_TRIG_BIT 16

// ----------------------------------------
// Reset values
// ----------------------------------------
`define RWS_FLAGS_RST 11'h001
`define RWS_EN_RST 5'h00

// ----------------------------------------
// Timing
// ----------------------------------------
`define RWS_CLK_PERIOD_NS 4
`define RWS_WARM_PULSE_NS 64
`define RWS_WARM_PULSE_CYC ((`RWS_WARM_PULSE_NS + `RWS_CLK_PERIOD_NS - 1) / `RWS_CLK_PERIOD_NS)

`endif

// file: rtl/rws_pkg.sv
// Types of the reset and wake status block
package rws_pkg;

  // ----------------------------------------
  // Vector types
  // ----------------------------------------
  typedef logic [10:0] rws_flags_t;
  typedef logic [4:0] rws_irq_t;
  typedef logic [4:0] rws_cnt_t;

endpackage : rws_pkg

// file: rtl/rws_reset_wake_status.sv
// Reset and wake status register with APB access, warm reset trigger and wake interrupt
//
// Function
// R1: Event flags stay set until software clears them
// R2: Software reads status after every reset exit
// R3: Writing one to bit 16 asserts warm reset
// R4: Bit 15 enables the sync interrupt
// R5: Bit 14 enables the adapter-fail interrupt
// R6: Bit 13 enables the clock wake interrupt
// R7: Bit 12 enables the ring indicate interrupt
// R8: Bit 11 enables the wake key interrupt
// R9: Enable one passes event, zero masks it
// R10: Interrupt is a level while enabled flag set
// R11: Bit 10 reads the captured sync event
// R12: Writing one to bit 10 clears sync flag
// R13: Bit 9 records a watchdog warm reset
// R14: Writing one to bit 9 clears watchdog flag
// R15: Bits 8 to 0 are sticky clearable flags
// R16: Five wake sources merge into one interrupt
// R17: Set beats clear; bits 31 to 17 read zero
`include "rws_map.svh"

module rws_reset_wake_status
  import rws_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic porEvent,
  input wire logic [2:0] pllUnlockEvent,
  input wire logic wakeKeyEvent,
  input wire logic ringIndicateEvent,
  input wire logic rtcWakeEvent,
  input wire logic adapterGoodIn,
  input wire logic warmResetEvent,
  input wire logic watchdogResetEvent,
  input wire logic syncEvent,
  output logic warmResetOutN,
  output logic pmuIrq
);

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  function automatic logic [31:0] byteMask(input logic [3:0] strb);
    logic [31:0] m;
    m = 32'h00000000;
    for (int b = 0; b < 4; b++) begin
      m[b*8 +: 8] = {8{strb[b]}};
    end
    return m;
  endfunction : byteMask

  // Picks the five wake sources out of the flag vector in enable order
  function automatic rws_irq_t irqSources(input rws_flags_t f);
    return {f[`RWS_SYNC_BIT], f[`RWS_PFAIL_BIT], f[`RWS_RTC_BIT],
            f[`RWS_RING_BIT], f[`RWS_WAKE_BIT]}; // R16
  endfunction : irqSources

  // Spreads a wake-source vector back onto flag positions
  function automatic rws_flags_t irqToFlags(input rws_irq_t v);
    rws_flags_t f;
    f = 11'h000;
    f[`RWS_WAKE_BIT] = v[0];
    f[`RWS_RING_BIT] = v[1];
    f[`RWS_RTC_BIT] = v[2];
    f[`RWS_PFAIL_BIT] = v[3];
    f[`RWS_SYNC_BIT] = v[4];
    return f;
  endfunction : irqToFlags

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  rws_flags_t evRaw;
  rws_flags_t evSync1Ff;
  rws_flags_t evSync2Ff;
  rws_flags_t flagsFf;
  rws_flags_t nxt_flagsFf;
  rws_flags_t clrMask;
  rws_irq_t enFf;
  rws_irq_t nxt_enFf;
  rws_cnt_t warmCntFf;
  rws_cnt_t warmLowCntFf;
  logic warmResetOutNFf;
  logic irqFf;
  logic [31:0] prdataFf;
  logic [31:0] wMask;
  logic [31:0] strbMask;
  logic setupRd;
  logic accWr;
  logic hitStatus;
  logic hitIrqStat;
  logic hitIrqClr;
  logic hitIrqEn;
  logic mapped;
  logic wrStatus;
  logic wrIrqClr;
  logic wrIrqEn;
  logic warmTrig;

  // ----------------------------------------
  // Event synchroniser
  // ----------------------------------------
  assign evRaw = {syncEvent, watchdogResetEvent, warmResetEvent, ~adapterGoodIn,
                  rtcWakeEvent, ringIndicateEvent, wakeKeyEvent, pllUnlockEvent, porEvent};

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      evSync1Ff <= 11'h000;
      evSync2Ff <= 11'h000;
    end else begin
      evSync1Ff <= evRaw;
      evSync2Ff <= evSync1Ff;
    end
  end

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  assign hitStatus = (paddr == `RWS_STATUS_ADDR);
  assign hitIrqStat = (paddr == `RWS_IRQ_STAT_ADDR);
  assign hitIrqClr = (paddr == `RWS_IRQ_CLR_ADDR);
  assign hitIrqEn = (paddr == `RWS_IRQ_EN_ADDR);
  assign mapped = hitStatus | hitIrqStat | hitIrqClr | hitIrqEn;
  assign setupRd = psel & ~penable & ~pwrite;
  assign accWr = psel & penable & pwrite & mapped;
  assign strbMask = byteMask(pstrb);
  assign wMask = pwdata & strbMask;
  assign wrStatus = accWr & hitStatus;
  assign wrIrqClr = accWr & hitIrqClr;
  assign wrIrqEn = accWr & hitIrqEn;
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;

  // ----------------------------------------
  // Sticky event flags
  // ----------------------------------------
  always_comb begin
    clrMask = 11'h000;
    if (wrStatus) begin
      clrMask = wMask[`RWS_SYNC_BIT:`RWS_POR_BIT]; // R12 R14 R15
    end else if (wrIrqClr) begin
      clrMask = irqToFlags(wMask[4:0]);
    end
    nxt_flagsFf = (flagsFf & ~clrMask) | evSync2Ff; // R1 R13 R17
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flagsFf <= `RWS_FLAGS_RST;
    end else begin
      flagsFf <= nxt_flagsFf;
    end
  end

  // ----------------------------------------
  // Interrupt enables
  // ----------------------------------------
  always_comb begin
    nxt_enFf = enFf;
    if (wrStatus) begin
      nxt_enFf = (enFf & ~strbMask[`RWS_EN_HI_BIT:`RWS_EN_LO_BIT]) |
                 wMask[`RWS_EN_HI_BIT:`RWS_EN_LO_BIT]; // R4 R5 R6 R7 R8
    end else if (wrIrqEn) begin
      nxt_enFf = (enFf & ~strbMask[4:0]) | wMask[4:0];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      enFf <= `RWS_EN_RST;
    end else begin
      enFf <= nxt_enFf;
    end
  end

  // ----------------------------------------
  // Interrupt output
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqFf <= 1'b0;
    end else begin
      irqFf <= |(irqSources(nxt_flagsFf) & nxt_enFf); // R9 R10 R16
    end
  end

  assign pmuIrq = irqFf;

  // ----------------------------------------
  // Warm reset trigger
  // ----------------------------------------
  assign warmTrig = wrStatus & wMask[`RWS_WARM_TRIG_BIT];

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      warmCntFf <= 5'h00;
      warmResetOutNFf <= 1'b1;
    end else if (warmTrig) begin
      warmCntFf <= rws_cnt_t'(`RWS_WARM_PULSE_CYC - 1); // R3
      warmResetOutNFf <= 1'b0;
    end else if (warmCntFf != 5'h00) begin
      warmCntFf <= warmCntFf - 5'h01;
    end else begin
      warmResetOutNFf <= 1'b1;
    end
  end

  assign warmResetOutN = warmResetOutNFf;

  // Low-time counter, restarted by every trigger
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      warmLowCntFf <= 5'h00;
    end else if (warmTrig) begin
      warmLowCntFf <= 5'h00;
    end else if (!warmResetOutNFf && warmLowCntFf != 5'h1F) begin
      warmLowCntFf <= warmLowCntFf + 5'h01;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      prdataFf <= 32'h00000000;
    end else if (setupRd) begin
      if (hitStatus) begin
        prdataFf <= {15'h0000, 1'b0, enFf, flagsFf}; // R11 R17
      end else if (hitIrqStat) begin
        prdataFf <= {27'h0000000, irqSources(flagsFf)};
      end else if (hitIrqEn) begin
        prdataFf <= {27'h0000000, enFf};
      end else begin
        prdataFf <= 32'h00000000;
      end
    end
  end

  assign prdata = prdataFf;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  sticky_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R1
    1 |=> (($past(flagsFf) & ~$past(clrMask) & ~flagsFf) == 11'h000))
    else $error("sticky flag dropped without a clear");

  event_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R17
    1 |=> (($past(evSync2Ff) & ~flagsFf) == 11'h000))
    else $error("event did not set its flag");

  flag_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R12
    (wrStatus && wMask[`RWS_SYNC_BIT] && !evSync2Ff[`RWS_SYNC_BIT])
    |=> !flagsFf[`RWS_SYNC_BIT])
    else $error("sync flag not cleared by write of one");

  wdt_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R14
    (wrStatus && !wMask[`RWS_WDT_BIT] && flagsFf[`RWS_WDT_BIT])
    |=> flagsFf[`RWS_WDT_BIT])
    else $error("watchdog flag cleared by write of zero");

  warm_pulse_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R3
    warmTrig |=> !warmResetOutN [*8] ##1 !warmResetOutN [*8] ##1 warmResetOutN)
    else $error("warm reset pulse wrong");

  warm_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R3
    (wrStatus && !wMask[`RWS_WARM_TRIG_BIT] && warmResetOutN && warmCntFf == 5'h00)
    |=> warmResetOutN)
    else $error("warm reset asserted by write of zero");

  enable_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R8
    (wrStatus && pstrb[1]) |=> (enFf == $past(pwdata[`RWS_EN_HI_BIT:`RWS_EN_LO_BIT])))
    else $error("enable bits not written");

  irq_level_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R10
    (|(irqSources(flagsFf) & enFf)) |-> pmuIrq)
    else $error("interrupt low while enabled flag set");

  irq_mask_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R9
    ((irqSources(flagsFf) & enFf) == 5'h00) |-> !pmuIrq)
    else $error("masked event raised interrupt");

  sync_read_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R11
    (setupRd && hitStatus) |=> (prdata[`RWS_SYNC_BIT] == $past(flagsFf[`RWS_SYNC_BIT])))
    else $error("sync flag read wrong");

  reserved_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R17
    (setupRd && hitStatus) |=> (prdata[31:16] == 16'h0000))
    else $error("reserved bits read nonzero");

  unmapped_err_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (psel && penable && !mapped) |-> (pslverr && pready))
    else $error("unmapped access without error");

  warm_length_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R3
    $rose(warmResetOutN) |-> (warmLowCntFf == rws_cnt_t'(`RWS_WARM_PULSE_CYC)))
    else $error("warm reset pulse length wrong");

  en_sync_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R4
    (wrStatus && pstrb[1]) |=> (enFf[4] == $past(pwdata[`RWS_EN_LO_BIT + 4])))
    else $error("sync enable not written");

  en_adapter_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R5
    (wrStatus && pstrb[1]) |=> (enFf[3] == $past(pwdata[`RWS_EN_LO_BIT + 3])))
    else $error("adapter enable not written");

  en_rtc_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R6
    (wrStatus && pstrb[1]) |=> (enFf[2] == $past(pwdata[`RWS_EN_LO_BIT + 2])))
    else $error("clock wake enable not written");

  en_ring_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R7
    (wrStatus && pstrb[1]) |=> (enFf[1] == $past(pwdata[`RWS_EN_LO_BIT + 1])))
    else $error("ring enable not written");

  en_wake_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R8
    (wrStatus && pstrb[1]) |=> (enFf[0] == $past(pwdata[`RWS_EN_LO_BIT])))
    else $error("wake key enable not written");

  irq_en_wr_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R9
    (wrIrqEn && pstrb[0]) |=> (enFf == $past(pwdata[4:0])))
    else $error("enable alias not written");

  wdt_set_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R13
    evSync2Ff[`RWS_WDT_BIT] |=> flagsFf[`RWS_WDT_BIT])
    else $error("watchdog flag not set");

  w1c_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R15
    wrStatus |=> ((flagsFf & $past(wMask[`RWS_SYNC_BIT:`RWS_POR_BIT]) &
                   ~$past(evSync2Ff)) == 11'h000))
    else $error("flag not cleared by write of one");

  irq_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_n) // R16
    wrIrqClr |=> ((irqSources(flagsFf) & $past(wMask[4:0]) &
                   ~irqSources($past(evSync2Ff))) == 5'h00))
    else $error("wake source not cleared");

endmodule : rws_reset_wake_status

// file: verif/tb_top.sv
// Self-checking bench of the reset and wake status register
`include "rws_map.svh"

module tb_top
  import rws_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, warmResetOutN, pmuIrq;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [10:0] ev;
  rws_flags_t expFlags;
  rws_irq_t en;
  logic [10:0] clr;
  logic [10:0] evPat;
  logic [3:0] strb;
  logic err;
  int seed = 32'hb4c2;
  int nMismatch = 0;
  int totalChecks = 0;

  rws_reset_wake_status rws_reset_wake_status_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .porEvent(ev[0]), .pllUnlockEvent(ev[3:1]), .wakeKeyEvent(ev[4]),
    .ringIndicateEvent(ev[5]), .rtcWakeEvent(ev[6]), .adapterGoodIn(~ev[7]),
    .warmResetEvent(ev[8]), .watchdogResetEvent(ev[9]), .syncEvent(ev[10]),
    .warmResetOutN(warmResetOutN), .pmuIrq(pmuIrq));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic end_of_test();
    if (nMismatch == 0 && totalChecks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    totalChecks++;
    if (g !== e) begin
      nMismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  function automatic logic expIrq(input logic [4:0] m, input logic [10:0] f);
    return |(m & {f[10], f[7], f[6], f[5], f[4]});
  endfunction : expIrq

  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk(32'h0, 32'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
    chk(err, 0);
  endtask : wr

  task automatic rdChk(input logic [31:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask : rdChk

  task automatic pulse(input logic [10:0] p);
    @(posedge sys_clk);
    ev <= p;
    repeat (4) @(posedge sys_clk);
    ev <= 11'h000;
    repeat (4) @(posedge sys_clk);
  endtask : pulse

  task automatic status();
    rdChk(`RWS_STATUS_ADDR, {16'h0, en, expFlags});
  endtask : status

  // ----------------------------------------
  // Clock and watchdog
  // ----------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  initial begin
    #200000;
    nMismatch++;
    end_of_test();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    ev = 11'h000;
    strb = 4'hF;
    expFlags = 11'h001;
    en = 5'h00;
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    chk({warmResetOutN, pmuIrq}, 2'h2);
    status();
    for (int i = 0; i < 11; i++) begin
      pulse(11'h001 << i);
      expFlags = expFlags | (11'h001 << i);
      status();
      wr(`RWS_STATUS_ADDR, 32'h1 << i);
      expFlags = expFlags & ~(11'h001 << i);
      status();
    end
    for (int k = 0; k < 24; k++) begin
      evPat = 11'($random(seed));
      pulse(evPat);
      expFlags = expFlags | evPat;
      en = 5'($random(seed));
      clr = 11'($random(seed));
      wr(`RWS_STATUS_ADDR, {16'h0, en, clr});
      expFlags = expFlags & ~clr;
      repeat (2) @(posedge sys_clk);
      chk(pmuIrq, expIrq(en, expFlags));
      status();
      rdChk(`RWS_IRQ_STAT_ADDR, {27'h0, expFlags[10], expFlags[7:4]});
      rdChk(`RWS_IRQ_EN_ADDR, {27'h0, en});
    end
    @(posedge sys_clk);
    ev <= 11'h400;
    repeat (4) @(posedge sys_clk);
    wr(`RWS_STATUS_ADDR, {16'h0, en, 11'h400});
    expFlags = expFlags | 11'h400;
    status();
    wr(`RWS_IRQ_EN_ADDR, 32'h10);
    en = 5'h10;
    repeat (2) @(posedge sys_clk);
    chk(pmuIrq, 1);
    @(posedge sys_clk);
    ev <= 11'h000;
    repeat (4) @(posedge sys_clk);
    wr(`RWS_IRQ_CLR_ADDR, 32'h10);
    expFlags = expFlags & ~11'h400;
    repeat (2) @(posedge sys_clk);
    chk(pmuIrq, 0);
    wr(`RWS_STATUS_ADDR, {16'h1, en, 11'h000});
    repeat (16) begin
      @(negedge sys_clk);
      chk(warmResetOutN, 0);
    end
    @(negedge sys_clk);
    chk(warmResetOutN, 1);
    status();
    pulse(11'h7FF);
    expFlags = 11'h7FF;
    strb <= 4'h1;
    wr(`RWS_STATUS_ADDR, 32'h0001FFFF);
    strb <= 4'hF;
    expFlags = 11'h700;
    status();
    chk(pmuIrq, expIrq(en, expFlags));
    wr(`RWS_STATUS_ADDR, 32'hFFFE0000 | {16'h0, en, 11'h000});
    status();
    apb(1'b0, 32'h80001024, 32'h0);
    chk(err, 1);
    chk(rd, 32'h0);
    apb(1'b1, 32'h80001024, 32'hFFFFFFFF);
    chk(err, 1);
    status();
    @(posedge sys_clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk({warmResetOutN, pmuIrq}, 2'h2);
    chk(prdata, 32'h0);
    rst_n <= 1'b1;
    expFlags = 11'h001;
    en = 5'h00;
    status();
    end_of_test();
  end
endmodule : tb_top
